// ---- hdl/i2c_slave_params.svh ----
// Constants of the slave-side two-wire serial interface
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// ==========================================================
// Byte framing
`define BIT_CNT_RST   4'h0   // Bit counter at the start of a byte
`define BIT_CNT_STEP  4'h1   // One SCL rise
`define DATA_BITS     4'h8   // Rises that carry data bits
`define ACK_SLOT      4'h9   // Rise that carries the acknowledge bit
`define TX_BIT_FIRST  4'h1   // First rise after which a new bit is driven
`define TX_BIT_LAST   4'h7   // Last rise after which a new bit is driven

// ==========================================================
// Address byte layout
`define MCODE_HI      5'h01  // Upper five bits of a high-speed master code
`define DIR_READ      1'b1   // Direction bit value for a master read
`define ADDR_PRESET_DEF 5'h0B // Arbitrary value, not taken from any part

`endif

// ---- hdl/i2c_slave_pkg.sv ----
// Types shared by the slave-side two-wire serial interface
package i2c_slave_pkg;

    // Protocol position of the slave
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WRITE,
        ST_READ,
        ST_IGNORE
    } bus_state_t;

    // One received byte with its strobe
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } rx_byte_t;

    // Link status seen by the user side
    typedef struct packed {
        logic busy;
        logic hs;
        logic selected;
        logic reading;
    } link_status_t;

    // Complete state of the system-clock side
    typedef struct packed {
        logic         scl_m;
        logic         scl_s;
        logic         scl_p;
        logic         sda_m;
        logic         sda_s;
        logic         sda_p;
        logic [1:0]   asel_m;
        logic [1:0]   asel_s;
        bus_state_t   state;
        logic [3:0]   bit_cnt;
        logic         nack;
        logic         stretch;
        logic         first_pending;
        logic [7:0]   tx_sh;
        logic         sda_oe;
        logic         scl_oe;
        logic         drive_lvl;
        logic         tx_taken;
        rx_byte_t     rx;
        link_status_t status;
    } slave_state_t;

endpackage : i2c_slave_pkg

// ---- hdl/i2c_slave_hs_interface.sv ----
// Slave end of a two-wire serial bus with high-speed mode support
`timescale 1ns/100ps
`include "i2c_slave_params.svh"

module i2c_slave_hs_interface
    import i2c_slave_pkg::*;
#(
    parameter logic [4:0] ADDR_PRESET = `ADDR_PRESET_DEF // Arbitrary
) (
    input  wire logic         CLK,
    input  wire logic         RST_N,
    input  wire logic         CE,
    input  wire logic         SCL_I,
    output logic              SCL_O,
    output logic              SCL_OE,
    input  wire logic         SDA_I,
    output logic              SDA_O,
    output logic              SDA_OE,
    input  wire logic         ADDR_SELECT_HI_PIN,
    input  wire logic         ADDR_SELECT_LO_PIN,
    input  wire logic [7:0]   TX_DATA,
    input  wire logic         TX_VALID,
    output logic              TX_TAKEN,
    output rx_byte_t          RX,
    output link_status_t      STATUS
);

    // ==========================================================
    // Link domain
    // Bits are shifted on the bus clock itself, so data sampling works
    // without oversampling; bits are counted on synchronised SCL edges, and the byte is read by the system side
    // only after the eighth rise, when it stays still for a whole
    // low phase of SCL.
    logic [7:0] link_sh;

    always_ff @(posedge SCL_I) begin
        link_sh <= {link_sh[6:0], SDA_I};
    end

    // ==========================================================
    // Bus condition detection
    slave_state_t st_reg;
    slave_state_t st_next;
    logic         start_det;
    logic         stop_det;
    logic         cond_ev;
    logic         scl_rise;
    logic         scl_fall;
    logic         addr_match;
    logic         addr_done;

    // Edges are taken from the second and third synchroniser stages
    assign scl_rise  = st_reg.scl_s & ~st_reg.scl_p;
    assign scl_fall  = ~st_reg.scl_s & st_reg.scl_p;
    assign start_det = st_reg.scl_s & st_reg.scl_p
                     & st_reg.sda_p & ~st_reg.sda_s;
    assign stop_det  = st_reg.scl_s & st_reg.scl_p
                     & ~st_reg.sda_p & st_reg.sda_s;
    assign cond_ev   = start_det | stop_det;

    // Preset bits plus the select pins, compared after the direction bit
    assign addr_match = (link_sh[7:3] == ADDR_PRESET)
                      && (link_sh[2:1] == st_reg.asel_s);

    // Falling edge that closes the address byte
    assign addr_done = CE && !cond_ev && !st_reg.stretch && scl_fall
                     && (st_reg.state == ST_ADDR)
                     && (st_reg.bit_cnt == `DATA_BITS);

    // ==========================================================
    // Transmit load
    // Puts a byte in the shifter and drives its MSB; also ends a stretch
    function automatic slave_state_t load_tx(input slave_state_t s,
                                             input logic [7:0]   d);
        slave_state_t t;
        t          = s;
        t.tx_sh    = d;
        t.sda_oe   = ~d[7];
        t.tx_taken = 1'b1;
        t.scl_oe   = 1'b0;
        t.stretch  = 1'b0;
        return t;
    endfunction : load_tx

    // ==========================================================
    // Protocol engine
    always_comb begin
        st_next = st_reg;
        // Three-stage synchronisers for SCL and SDA, two stages for the select pins
        st_next.scl_m  = SCL_I;
        st_next.scl_s  = st_reg.scl_m;
        st_next.scl_p  = st_reg.scl_s;
        st_next.sda_m  = SDA_I;
        st_next.sda_s  = st_reg.sda_m;
        st_next.sda_p  = st_reg.sda_s;
        st_next.asel_m = {ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN};
        st_next.asel_s = st_reg.asel_m;
        // Pulses last one cycle
        st_next.rx.valid = 1'b0;
        st_next.tx_taken = 1'b0;

        if (start_det) begin
            // Fresh address byte; any byte in flight is dropped
            st_next.state   = ST_ADDR;
            st_next.bit_cnt = `BIT_CNT_RST;
            st_next.sda_oe  = 1'b0;
            st_next.scl_oe  = 1'b0;
            st_next.stretch = 1'b0;
            st_next.nack    = 1'b0;
        end else if (stop_det) begin
            // Bus free again and high-speed mode ends
            st_next.state     = ST_IDLE;
            st_next.bit_cnt   = `BIT_CNT_RST;
            st_next.sda_oe    = 1'b0;
            st_next.scl_oe    = 1'b0;
            st_next.stretch   = 1'b0;
            st_next.status.hs = 1'b0;
        end else if (st_reg.stretch) begin
            // SCL is held low until the user offers the next byte
            if (TX_VALID) begin
                st_next = load_tx(st_next, TX_DATA);
            end
        end else if (scl_rise && st_reg.state != ST_IDLE) begin
            st_next.bit_cnt = st_reg.bit_cnt + `BIT_CNT_STEP;
            // Master answer to a byte we sent
            if (st_reg.state == ST_READ && st_reg.bit_cnt == `DATA_BITS) begin
                st_next.nack = st_reg.sda_s;
            end
        end else if (scl_fall) begin
            case (st_reg.state)
                ST_ADDR: begin
                    if (st_reg.bit_cnt == `DATA_BITS) begin
                        if (link_sh[7:3] == `MCODE_HI) begin
                            // Master code: no acknowledge, wait for Sr
                            st_next.status.hs = 1'b1;
                            st_next.state     = ST_IGNORE;
                        end else if (addr_match) begin
                            st_next.sda_oe         = 1'b1;
                            st_next.status.reading =
                                (link_sh[0] == `DIR_READ);
                            st_next.first_pending  = 1'b1;
                        end else begin
                            st_next.state = ST_IGNORE;
                        end
                    end else if (st_reg.bit_cnt == `ACK_SLOT) begin
                        st_next.sda_oe  = 1'b0;
                        st_next.bit_cnt = `BIT_CNT_RST;
                        if (st_reg.status.reading) begin
                            st_next.state = ST_READ;
                            if (st_reg.status.hs && !TX_VALID) begin
                                st_next.scl_oe  = 1'b1;
                                st_next.stretch = 1'b1;
                            end else begin
                                st_next = load_tx(st_next, TX_DATA);
                            end
                        end else begin
                            st_next.state = ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (st_reg.bit_cnt == `DATA_BITS) begin
                        // Acknowledge every byte, however many come
                        st_next.sda_oe        = 1'b1;
                        st_next.rx.valid      = 1'b1;
                        st_next.rx.data       = link_sh;
                        st_next.rx.first      = st_reg.first_pending;
                        st_next.first_pending = 1'b0;
                    end else if (st_reg.bit_cnt == `ACK_SLOT) begin
                        st_next.sda_oe  = 1'b0;
                        st_next.bit_cnt = `BIT_CNT_RST;
                    end
                end
                ST_READ: begin
                    if (st_reg.bit_cnt >= `TX_BIT_FIRST
                        && st_reg.bit_cnt <= `TX_BIT_LAST) begin
                        // Next bit, changed while SCL is low
                        st_next.sda_oe = ~st_reg.tx_sh[6];
                        st_next.tx_sh  = {st_reg.tx_sh[6:0], 1'b0};
                    end else if (st_reg.bit_cnt == `DATA_BITS) begin
                        st_next.sda_oe = 1'b0; // Master's acknowledge
                    end else if (st_reg.bit_cnt == `ACK_SLOT) begin
                        st_next.bit_cnt = `BIT_CNT_RST;
                        if (st_reg.nack) begin
                            st_next.state = ST_IGNORE;
                        end else if (st_reg.status.hs && !TX_VALID) begin
                            st_next.scl_oe  = 1'b1;
                            st_next.stretch = 1'b1;
                        end else begin
                            st_next = load_tx(st_next, TX_DATA);
                        end
                    end
                end
                default: begin
                    // Idle or ignoring: the pins are left alone
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end

        // Status is registered together with the state it reports
        st_next.status.busy     = (st_next.state != ST_IDLE);
        st_next.status.selected = (st_next.state == ST_READ)
                               || (st_next.state == ST_WRITE);
    end

    // ==========================================================
    // State register
    // Clock enable freezes the whole state register, synchronisers included
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg <= slave_state_t'('0);
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // Open-drain pins: the level flop stays low, only enables move
    assign SCL_O    = st_reg.drive_lvl;
    assign SCL_OE   = st_reg.scl_oe;
    assign SDA_O    = st_reg.drive_lvl;
    assign SDA_OE   = st_reg.sda_oe;
    assign TX_TAKEN = st_reg.tx_taken;
    assign RX       = st_reg.rx;
    assign STATUS   = st_reg.status;

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_addr_done;
        addr_done;
    endsequence

    sequence s_mcode;
        addr_done && (link_sh[7:3] == `MCODE_HI);
    endsequence

    sequence s_wr_byte;
        CE && !cond_ev && scl_fall && (st_reg.state == ST_WRITE)
            && (st_reg.bit_cnt == `DATA_BITS);
    endsequence

    sequence s_rd_nack;
        CE && !cond_ev && !st_reg.stretch && scl_fall
            && (st_reg.state == ST_READ)
            && (st_reg.bit_cnt == `ACK_SLOT) && st_reg.nack;
    endsequence

    property p_start;
        CE && start_det |=> (st_reg.state == ST_ADDR)
            && (st_reg.bit_cnt == `BIT_CNT_RST) && !SCL_OE;
    endproperty
    a_start: assert property (p_start)
        else $error("START not followed by address reception");

    property p_stop;
        CE && stop_det |=> (st_reg.state == ST_IDLE)
            && !SDA_OE && !STATUS.hs && !STATUS.busy;
    endproperty
    a_stop: assert property (p_stop)
        else $error("STOP did not free the bus");

    property p_scl_fs;
        !STATUS.hs |-> !SCL_OE;
    endproperty
    a_scl_fs: assert property (p_scl_fs)
        else $error("SCL driven outside high-speed mode");

    property p_sda_edge;
        ($rose(SDA_OE) || $fell(SDA_OE))
            |-> !$past(st_reg.scl_s) || $past(cond_ev);
    endproperty
    a_sda_edge: assert property (p_sda_edge)
        else $error("SDA drive changed while SCL high");

    property p_mcode;
        s_mcode |=> !SDA_OE && STATUS.hs && (st_reg.state == ST_IGNORE);
    endproperty
    a_mcode: assert property (p_mcode)
        else $error("Master code acknowledged or hs not entered");

    property p_match_ack;
        (s_addr_done and (addr_match && (link_sh[7:3] != `MCODE_HI)))
            |=> SDA_OE && (STATUS.reading == $past(link_sh[0]));
    endproperty
    a_match_ack: assert property (p_match_ack)
        else $error("Matching address not acknowledged");

    property p_mismatch;
        (s_addr_done and !addr_match)
            |=> !SDA_OE && (st_reg.state == ST_IGNORE);
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("Foreign address not ignored");

    property p_hs_keep;
        STATUS.hs && !(CE && stop_det) |=> STATUS.hs;
    endproperty
    a_hs_keep: assert property (p_hs_keep)
        else $error("High-speed mode left without STOP");

    property p_wr_byte;
        s_wr_byte |=> RX.valid && SDA_OE && (RX.data == $past(link_sh))
            ##1 !RX.valid;
    endproperty
    a_wr_byte: assert property (p_wr_byte)
        else $error("Received byte not delivered or acknowledged");

    property p_nack;
        s_rd_nack |=> !SDA_OE && (st_reg.state == ST_IGNORE);
    endproperty
    a_nack: assert property (p_nack)
        else $error("SDA not released after master NACK");

endmodule : i2c_slave_hs_interface

// ---- verification/i2c_master_model.sv ----
// Behavioural bus master driving the far side of the slave interface
`timescale 1ns/100ps

module i2c_master_model (
    input  wire logic LCLK,
    input  wire logic SCL,
    input  wire logic SDA,
    output logic      SCL_LOW,
    output logic      SDA_LOW
);
    int hangs;

    // ==========================================================
    // Line drive
    // Both lines released after power-up, so the bus starts idle
    initial begin
        SCL_LOW = 1'b0;
        SDA_LOW = 1'b0;
        hangs   = 0;
    end

    // One bit: data moves in the low phase, is sampled in the high phase
    task automatic put_bit(input logic b, output logic s);
        int n;
        n = 0;
        @(posedge LCLK) SDA_LOW <= ~b;
        @(posedge LCLK) SCL_LOW <= 1'b0;
        // The slave may stretch; wait until every party lets go
        while (SCL !== 1'b1 && n < 2000) begin
            @(posedge LCLK);
            n++;
        end
        if (n == 2000) hangs++;
        @(posedge LCLK) s = SDA;
        @(posedge LCLK) SCL_LOW <= 1'b1;
    endtask : put_bit

    // START or repeated START, only from an idle bus or a low clock
    task automatic start_cond();
        @(posedge LCLK) SDA_LOW <= 1'b0;
        @(posedge LCLK) SCL_LOW <= 1'b0;
        @(posedge LCLK) SDA_LOW <= 1'b1;
        @(posedge LCLK) SCL_LOW <= 1'b1;
    endtask : start_cond

    // STOP leaves both lines released; the clock stands still after it
    task automatic stop_cond();
        @(posedge LCLK) SDA_LOW <= 1'b1;
        @(posedge LCLK) SCL_LOW <= 1'b0;
        @(posedge LCLK) SDA_LOW <= 1'b0;
        @(posedge LCLK);
    endtask : stop_cond

    // Eight bits MSB first, then a ninth clock for the acknowledge
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask : write_byte

    // Read eight bits; answer the last byte of a read with NACK
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(~ack, s);
    endtask : read_byte
endmodule : i2c_master_model

// ---- verification/i2c_slave_hs_interface_tb.sv ----
// Self-checking bench for the slave-side two-wire serial interface
`timescale 1ns/100ps
`include "i2c_slave_params.svh"

module i2c_slave_hs_interface_tb import i2c_slave_pkg::*;;
    localparam logic [4:0] PRESET = `ADDR_PRESET_DEF
    ;
    logic         clk, rst_n, lclk, hi, lo, tx_valid, tx_taken, a, s;
    logic         scl_oe, sda_oe, m_scl_low, m_sda_low, scl_q, oe_q;
    logic         ce, scl_lvl, sda_lvl;
    logic [7:0]   tx_data;
    rx_byte_t     rx;
    link_status_t status;
    rx_byte_t     rxq[$];
    logic [7:0]   txq[$];
    int           fails, checks, n;
    // Open-drain lines with pull-ups; the slave pulls low only at level 0
    wire          scl = ~(m_scl_low | (scl_oe & ~scl_lvl));
    wire          sda = ~(m_sda_low | (sda_oe & ~sda_lvl));

    // ==========================================================
    // Clocks and instances
    always #10 clk = ~clk;
    // Link tick offset so its edges never meet the system clock
    initial begin
        lclk = 1'b0;
        #7;
        forever #40 lclk = ~lclk;
    end

    i2c_slave_hs_interface u_dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .SCL_I(scl), .SCL_O(scl_lvl),
        .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_lvl), .SDA_OE(sda_oe),
        .ADDR_SELECT_HI_PIN(hi), .ADDR_SELECT_LO_PIN(lo),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_TAKEN(tx_taken),
        .RX(rx), .STATUS(status)
    );

    i2c_master_model u_m (
        .LCLK(lclk), .SCL(scl), .SDA(sda),
        .SCL_LOW(m_scl_low), .SDA_LOW(m_sda_low)
    );

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (u_m.hangs != 0) fails++;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic timeout();
        fails++;
        end_of_test();
    endtask : timeout

    initial begin
        #1000000;
        timeout();
    end

    // Strobes are caught at the falling edge, after registers settle
    always @(negedge clk) begin
        if (rx.valid === 1'b1) rxq.push_back(rx);
        if (tx_taken === 1'b1) begin
            txq.push_back(tx_data);
            tx_data <= 8'($urandom);
        end
        // Device data drive may only move while the clock is low
        if (scl_q === 1'b1 && scl === 1'b1) check(sda_oe, oe_q);
        scl_q <= scl;
        oe_q <= sda_oe;
    end

    function automatic logic [7:0] addr_byte(input logic dir);
        return {PRESET, hi, lo, dir};
    endfunction : addr_byte

    // ==========================================================
    // Transfers; each opens with START or repeated START
    task automatic do_write(input int cnt, input logic [3:0] st);
        logic [7:0] v;
        rx_byte_t   r;
        rxq.delete();
        u_m.start_cond();
        u_m.write_byte(addr_byte(1'b0), a);
        check(a, 1'b1);
        for (int i = 0; i < cnt; i++) begin
            v = 8'($urandom);
            u_m.write_byte(v, a);
            check(a, 1'b1);
            r = rxq.pop_front();
            check({r.valid, r.first, r.data}, {1'b1, i == 0, v});
        end
        check(status, st);
    endtask : do_write

    task automatic do_read(input int cnt, input logic [3:0] st);
        logic [7:0] v;
        txq.delete();
        u_m.start_cond();
        u_m.write_byte(addr_byte(1'b1), a);
        check(a, 1'b1);
        repeat (6) @(negedge clk);
        check(status, st);
        for (int i = 0; i < cnt; i++) begin
            u_m.read_byte(i < cnt - 1, v);
            check(v, txq.pop_front());
        end
        repeat (10) @(negedge clk);
        check({sda_oe, sda}, 2'b01);
    endtask : do_read

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {hi, lo} = 2'b00;
        tx_data = 8'h00;
        ce = 1'b1;
        tx_valid = 1'b1;
        {fails, checks} = '0;
        {scl_q, oe_q} = 2'b10;
        void'($urandom(83));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check({status, rx.valid, tx_taken, sda_oe, scl_oe, scl_lvl, sda_lvl},
              10'h000);
        // Every select pin setting, random byte counts, then STOP
        for (int p = 0; p < 4; p++) begin
            {hi, lo} = 2'(p);
            repeat (4) @(negedge clk);
            do_write(1 + $urandom_range(2), 4'b1010);
            do_read(1 + $urandom_range(2), 4'b1011);
            u_m.stop_cond();
            repeat (8) @(negedge clk);
            check(status[3], 1'b0);
        end
        // Foreign address: no answer, following byte ignored
        rxq.delete();
        u_m.start_cond();
        u_m.write_byte(addr_byte(1'b0) ^ 8'h80, a);
        check(a, 1'b0);
        u_m.write_byte(8'h00, a);
        check({a, rxq.size() == 0}, 2'b01);
        u_m.stop_cond();
        // Every master code switches to high speed and is never answered
        for (int c = 0; c < 8; c++) begin
            u_m.start_cond();
            u_m.write_byte({5'h01, 3'(c)}, a);
            check({a, status[2]}, 2'b01);
        end
        do_write(2, 4'b1110);
        // High-speed read with no byte ready: the clock is held low
        @(negedge clk) tx_valid = 1'b0;
        // Two bytes: stretch after the address and again after a data ack
        fork
            do_read(2, 4'b1111);
            for (int k = 0; k < 2; k++) begin
                n = 0;
                while (scl_oe !== 1'b1 && n < 400) begin
                    @(negedge clk);
                    n++;
                end
                if (n == 400) timeout();
                repeat (30) @(negedge clk);
                check({scl, txq.size() == 0}, 2'b01);
                // Clock enable low freezes the stretch though data waits
                ce = 1'b0;
                tx_valid = 1'b1;
                repeat (5) @(negedge clk);
                check({scl, scl_oe, tx_taken}, 3'b010);
                ce = 1'b1;
                repeat (2) @(negedge clk);
                tx_valid = 1'b0;
            end
        join
        tx_valid = 1'b1;
        u_m.stop_cond();
        repeat (8) @(negedge clk);
        check(status[3:2], 2'b00);
        // Bytes cut short by a repeated START and by a STOP
        u_m.start_cond();
        u_m.write_byte(addr_byte(1'b0), a);
        for (int i = 0; i < 4; i++) u_m.put_bit(1'b0, s);
        do_write(1, 4'b1010);
        for (int i = 0; i < 3; i++) u_m.put_bit(1'b1, s);
        u_m.stop_cond();
        repeat (8) @(negedge clk);
        check({status[3], rxq.size() == 0}, 2'b01);
        end_of_test();
    end
endmodule : i2c_slave_hs_interface_tb
